// *** logic/link_regs.sv ***
// Module: host register bank for cycle timer, channel match, diagnostics and phy access
`timescale 1ns/100ps
// Function
// - Cycle timer at 14h: seconds bits 0-6, cycle 7-19, ticks 20-31, bit0 MSB.
// - Ticks at 24.576 MHz, cycles 8 kHz, seconds 1 Hz, gated by control bits.
// - Channel match register at 18h, resets zero, two 8-bit fields, 16-31 reserved.
// - First enable set: accept iso packets matching first field; bits 0-1 tag.
// - Second enable set: accept iso packets matching second field; bits 8-9 tag.
// - Diagnostic at 20h: snoop and full-access always writable, rest only under full-access.
// - Memory test: enable, clear address, access 80h from location 0, counter increments.
// - Memory test mode only while test bit and full-access bit both set.
// - Snoop bit makes receiver accept every packet using snoop layout.
// - Busy select bit chooses busy B when set, busy A when clear.
// - Bit 2 set on arbitration reset gap, bit 3 on subaction gap.
// - Address clear bit zeroes test address counter and mismatch flag.
// - Test write stores test tag bit into RAM extra control bit 33.
// - Mismatch flag sets when RAM control bit differs from test tag value.
// - Upper half of phy register issues requests; lower half holds replies.
// - Read request bit sends phy read, cleared once sent.
// - Write request bit sends phy write with address and data, cleared once sent.
// - Phy reply loads address 20-23, data 24-31 and raises info interrupt.
// - Phy access register at 24h, host read/write, resets zero.
module link_regs
   import link_regs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Control register bits held elsewhere
   input wire logic cycle_master,
   input wire logic cycle_source,
   input wire logic cycle_timer_enable,
   input wire logic cycle_start_tick,
   // Bus idle gap detectors
   input wire logic arb_reset_gap_det,
   input wire logic subaction_gap_det,
   // Phy interface
   output phy_req_s phy_req,
   input wire logic phy_req_ack,
   input phy_reply_s phy_reply,
   output logic phy_info_received_irq,
   // Receiver control
   output rx_ctrl_s rx_ctrl,
   output logic memory_test_mode
);

   // ******************************************
   // State
   // ******************************************
   typedef struct packed {
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] cycle_time;
      logic [31:0] iso_match;
      logic [31:0] diag;
      logic [31:0] phy_acc;
      logic [17:0] tick_acc;
      logic [RAM_AW-1:0] ram_addr;
      phy_state_e phy_st;
      phy_req_s req;
      logic irq;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // RAM word: 32 data bits plus the control bit (bit 33 in test numbering)
   logic [32:0] ram_mem [RAM_DEPTH];
   logic [32:0] ram_rd;
   logic ram_we;

   // Host byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   logic test_on;
   assign test_on = st_r.diag[DG_MEM_TEST] & st_r.diag[DG_FULL_ACC];
   assign ram_rd = ram_mem[st_r.ram_addr];

   // ******************************************
   // Next-state logic
   // ******************************************
   always_comb begin
      logic wr_go;
      logic rd_go;
      logic [31:0] wv;
      logic [31:0] dmask;
      logic [6:0] sec;
      logic [12:0] cyc;
      logic [11:0] off;
      logic tick;
      logic carry_sec;
      logic [18:0] acc_sum;
      wr_go = 1'b0;
      rd_go = 1'b0;
      wv = '0;
      dmask = '0;
      sec = '0;
      cyc = '0;
      off = '0;
      tick = 1'b0;
      carry_sec = 1'b0;
      acc_sum = '0;
      ram_we = 1'b0;
      st_nxt = st_r;
      // Address and data may arrive in either order
      if (s_axi_awvalid && !st_r.aw_have) begin
         st_nxt.aw_have = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_have) begin
         st_nxt.w_have = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      wr_go = st_r.aw_have && st_r.w_have && !st_r.bvalid;
      rd_go = s_axi_arvalid && !st_r.rvalid;

      // Cycle timer: fractional accumulator produces 24.576 MHz ticks from aclk
      sec = st_r.cycle_time[31:25];
      cyc = st_r.cycle_time[24:12];
      off = st_r.cycle_time[11:0];
      acc_sum = {1'b0, st_r.tick_acc} + {3'b000, TICK_INC};
      tick = 1'b0;
      if (cycle_timer_enable) begin
         if (acc_sum >= {1'b0, TICK_MOD}) begin
            st_nxt.tick_acc = 18'(acc_sum - {1'b0, TICK_MOD});
            tick = 1'b1;
         end else begin
            st_nxt.tick_acc = acc_sum[17:0];
         end
      end
      carry_sec = 1'b0;
      // A cycle slave with external source resyncs on cycle start; between starts it still wraps itself at offset 3071
      if (!cycle_master && cycle_source && cycle_start_tick && cycle_timer_enable) begin
         off = '0;
         if (cyc == 13'(CYCLE_COUNT_LAST)) begin
            cyc = '0;
            carry_sec = 1'b1;
         end else begin
            cyc = cyc + 13'd1;
         end
      end else if (tick) begin
         if (off == 12'(CYCLE_OFFSET_LAST)) begin
            off = '0;
            if (cyc == 13'(CYCLE_COUNT_LAST)) begin
               cyc = '0;
               carry_sec = 1'b1;
            end else begin
               cyc = cyc + 13'd1;
            end
         end else begin
            off = off + 12'd1;
         end
      end
      if (carry_sec) begin
         sec = (sec == 7'(SECONDS_LAST)) ? 7'd0 : sec + 7'd1;
      end
      st_nxt.cycle_time = {sec, cyc, off};

      // Gap flags set by hardware; set beats any host write in the same cycle
      // Host write decode
      if (wr_go) begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = RESP_OKAY;
         unique case (st_r.aw_addr)
            OFF_CYCLE_TIME: begin
               st_nxt.cycle_time = merge(st_r.cycle_time, st_r.w_data, st_r.w_strb);
            end
            OFF_ISO_MATCH: begin
               st_nxt.iso_match = merge(st_r.iso_match, st_r.w_data, st_r.w_strb) & ISO_MASK;
            end
            OFF_DIAG: begin
               dmask = st_r.diag[DG_FULL_ACC] ? DIAG_MASK : DIAG_ALWAYS_WR;
               wv = merge(st_r.diag, st_r.w_data, st_r.w_strb);
               st_nxt.diag = ((wv & dmask) | (st_r.diag & ~dmask)) & DIAG_MASK;
            end
            OFF_PHY_ACCESS: begin
               // Host owns the request half; reply half stays with the phy
               wv = merge(st_r.phy_acc, st_r.w_data, st_r.w_strb);
               st_nxt.phy_acc = (wv & PHY_HOST_MASK) | (st_r.phy_acc & PHY_REPLY_MASK);
            end
            OFF_RAM_TEST: begin
               if (test_on) begin
                  ram_we = 1'b1;
                  st_nxt.ram_addr = st_r.ram_addr + RAM_AW'(1);
               end else begin
                  st_nxt.bresp = RESP_SLVERR;
               end
            end
            default: begin
               st_nxt.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Host read decode
      if (rd_go) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = RESP_OKAY;
         st_nxt.rdata = '0;
         unique case (s_axi_araddr)
            OFF_CYCLE_TIME: st_nxt.rdata = st_r.cycle_time;
            OFF_ISO_MATCH: st_nxt.rdata = st_r.iso_match;
            OFF_DIAG: st_nxt.rdata = st_r.diag;
            OFF_PHY_ACCESS: st_nxt.rdata = st_r.phy_acc;
            OFF_RAM_TEST: begin
               if (test_on) begin
                  st_nxt.rdata = ram_rd[31:0];
                  st_nxt.ram_addr = st_nxt.ram_addr + RAM_AW'(1);
                  if (ram_rd[32] != st_r.diag[DG_TAG_VAL]) begin
                     st_nxt.diag[DG_TAG_ERR] = 1'b1;
                  end
               end else begin
                  st_nxt.rresp = RESP_SLVERR;
               end
            end
            default: st_nxt.rresp = RESP_SLVERR;
         endcase
      end

      // Address clear acts as a self-clearing strobe
      if (st_r.diag[DG_ADR_CLR]) begin
         st_nxt.ram_addr = '0;
         st_nxt.diag[DG_TAG_ERR] = 1'b0;
         st_nxt.diag[DG_ADR_CLR] = 1'b0;
      end
      if (arb_reset_gap_det) begin
         st_nxt.diag[DG_ARB_GAP] = 1'b1;
      end
      if (subaction_gap_det) begin
         st_nxt.diag[DG_SUB_GAP] = 1'b1;
      end

      // Phy request sequencer
      st_nxt.irq = 1'b0;
      unique case (st_r.phy_st)
         PHY_IDLE: begin
            if (st_r.phy_acc[PH_READ_REQ] || st_r.phy_acc[PH_WRITE_REQ]) begin
               st_nxt.req.valid = 1'b1;
               st_nxt.req.write = !st_r.phy_acc[PH_READ_REQ] && st_r.phy_acc[PH_WRITE_REQ];
               st_nxt.req.addr = st_r.phy_acc[27:24];
               st_nxt.req.data = st_r.phy_acc[23:16];
               st_nxt.phy_st = PHY_SEND;
            end
         end
         PHY_SEND: begin
            if (phy_req_ack) begin
               st_nxt.req.valid = 1'b0;
               st_nxt.phy_st = PHY_DONE;
            end
         end
         PHY_DONE: begin
            // Request sent: clear only the bit that was served
            if (st_r.req.write) begin
               st_nxt.phy_acc[PH_WRITE_REQ] = 1'b0;
            end else begin
               st_nxt.phy_acc[PH_READ_REQ] = 1'b0;
            end
            st_nxt.phy_st = PHY_WAIT;
         end
         PHY_WAIT: begin
            st_nxt.phy_st = PHY_IDLE;
         end
         default: begin
            st_nxt.phy_st = PHY_IDLE;
            st_nxt.req = '0;
         end
      endcase

      // Phy reply wins over any host write to the lower half
      if (phy_reply.valid) begin
         st_nxt.phy_acc[11:8] = phy_reply.addr;
         st_nxt.phy_acc[7:0] = phy_reply.data;
         st_nxt.irq = 1'b1;
      end
   end

   // ******************************************
   // Registers
   // ******************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.phy_st <= PHY_IDLE;
         st_r.cycle_time <= RST_CYCLE_TIME;
         st_r.iso_match <= RST_ISO_MATCH;
         st_r.diag <= RST_DIAG;
         st_r.phy_acc <= RST_PHY_ACCESS;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   // Test RAM write port; no reset because contents are don't-care
   always_ff @(posedge aclk) begin
      if (clk_en && ram_we) begin
         ram_mem[st_r.ram_addr] <= {st_r.diag[DG_TAG_VAL], st_r.w_data};
      end
   end

   // ******************************************
   // Outputs
   // ******************************************
   assign s_axi_awready = !st_r.aw_have;
   assign s_axi_wready = !st_r.w_have;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign phy_req = st_r.req;
   assign phy_info_received_irq = st_r.irq;
   assign memory_test_mode = test_on;
   // Receiver steering straight from stored fields
   assign rx_ctrl.promiscuous_receive = st_r.diag[DG_PROMISC];
   assign rx_ctrl.busy_ack_select = st_r.diag[DG_BUSY_SEL];
   assign rx_ctrl.first_channel_match = st_r.iso_match[31:24];
   assign rx_ctrl.second_channel_match = st_r.iso_match[23:16];
   // Enables are not in this register bank; tie to field nonzero would be a guess, so tie both enables to 1
   assign rx_ctrl.first_channel_enable = 1'b1;
   assign rx_ctrl.second_channel_enable = 1'b1;

endmodule // link_regs

// *** common/link_regs_pkg.sv ***
// Package: offsets, field positions, timing counts and carrier structs for the link register bank
package link_regs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CYCLE_TIME = 8'h14;
   localparam logic [7:0] OFF_ISO_MATCH = 8'h18;
   localparam logic [7:0] OFF_DIAG = 8'h20;
   localparam logic [7:0] OFF_PHY_ACCESS = 8'h24;
   localparam logic [7:0] OFF_RAM_TEST = 8'h80;
   // Reset values
   localparam logic [31:0] RST_CYCLE_TIME = 32'h0000_0000;
   localparam logic [31:0] RST_ISO_MATCH = 32'h0000_0000;
   localparam logic [31:0] RST_DIAG = 32'h0000_0000;
   localparam logic [31:0] RST_PHY_ACCESS = 32'h0000_0000;
   // Field positions, bit 0 is the MSB of the word (bit n lives at word bit 31-n)
   localparam int DG_PROMISC = 31;
   localparam int DG_BUSY_SEL = 30;
   localparam int DG_ARB_GAP = 29;
   localparam int DG_SUB_GAP = 28;
   localparam int DG_FULL_ACC = 27;
   localparam int DG_ADR_CLR = 26;
   localparam int DG_TAG_VAL = 25;
   localparam int DG_TAG_ERR = 24;
   localparam int DG_MEM_TEST = 23;
   localparam logic [31:0] DIAG_ALWAYS_WR = 32'h8800_0000;
   localparam logic [31:0] DIAG_MASK = 32'hff80_0000;
   localparam logic [31:0] ISO_MASK = 32'hffff_0000;
   localparam int PH_READ_REQ = 31;
   localparam int PH_WRITE_REQ = 30;
   localparam logic [31:0] PHY_HOST_MASK = 32'hcfff_0000;
   localparam logic [31:0] PHY_REPLY_MASK = 32'h0000_0fff;
   // Cycle timer limits and clock rates
   localparam int CYCLE_OFFSET_LAST = 3071;
   localparam int CYCLE_COUNT_LAST = 7999;
   localparam int SECONDS_LAST = 127;
   localparam int CLK_KHZ = 200000;
   localparam int TICK_KHZ = 24576;
   localparam logic [15:0] TICK_INC = 16'(TICK_KHZ);
   localparam logic [17:0] TICK_MOD = 18'(CLK_KHZ);
   // Local RAM for the memory test path
   localparam int RAM_DEPTH = 64;
   localparam int RAM_AW = 6;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [3:0] {
      PHY_IDLE = 4'b0001,
      PHY_SEND = 4'b0010,
      PHY_WAIT = 4'b0100,
      PHY_DONE = 4'b1000
   } phy_state_e;

   // Request towards the phy and reply from it
   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] addr;
      logic [7:0] data;
   } phy_req_s;

   typedef struct packed {
      logic valid;
      logic [3:0] addr;
      logic [7:0] data;
   } phy_reply_s;

   // Receive-side control exported to the packet receiver
   typedef struct packed {
      logic promiscuous_receive;
      logic busy_ack_select;
      logic first_channel_enable;
      logic second_channel_enable;
      logic [7:0] first_channel_match;
      logic [7:0] second_channel_match;
   } rx_ctrl_s;
endpackage

// *** test/link_regs_checker.sv ***
// Checker: port-level assertions for the link register bank
`timescale 1ns/100ps
module link_regs_checker
   import link_regs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire phy_req_s phy_req,
   input wire logic phy_req_ack,
   input wire phy_reply_s phy_reply,
   input wire logic phy_info_received_irq,
   input wire rx_ctrl_s rx_ctrl,
   input wire logic memory_test_mode
);
   // ********************************
   // Assertions, one clock domain
   // ********************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Steps of a phy request and of a bus write
   sequence s_req_wait;
      phy_req.valid && !phy_req_ack;
   endsequence
   sequence s_req_taken;
      phy_req.valid && phy_req_ack;
   endsequence
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   chk_req_hold: assert property (s_req_wait |=> phy_req.valid && $stable(phy_req))
      else $error("phy request changed while waiting");
   chk_req_drop: assert property (s_req_taken |=> !phy_req.valid)
      else $error("phy request not dropped after ack");
   chk_irq_follow: assert property (phy_reply.valid |=> phy_info_received_irq)
      else $error("no info interrupt after reply");
   chk_irq_cause: assert property (phy_info_received_irq |-> $past(phy_reply.valid))
      else $error("info interrupt without reply");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   chk_cfg_cause: assert property ($changed(rx_ctrl) || $changed(memory_test_mode) |->
      $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
      else $error("control output moved without a write");
endmodule // link_regs_checker

bind link_regs link_regs_checker i_link_regs_checker (.*);

// *** test/phy_model.sv ***
// Model: behavioural phy answering register requests
`timescale 1ns/100ps
module phy_model
   import link_regs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] ack_delay,
   input wire phy_req_s phy_req,
   output logic phy_req_ack,
   output phy_reply_s phy_reply
);
   logic [7:0] regs_r [16];
   logic [3:0] cnt_r;
   logic [3:0] radr_r;
   logic [2:0] pend_r;

   // Ack after a set delay; reply lines toggle when idle so stale data never looks valid
   always_ff @(posedge aclk) begin
      phy_reply.valid <= 1'b0;
      phy_reply.addr <= ~phy_reply.addr;
      phy_reply.data <= ~phy_reply.data;
      phy_req_ack <= 1'b0;
      if (pend_r != 3'd0) pend_r <= pend_r - 3'd1;
      if (pend_r == 3'd1) phy_reply <= '{1'b1, radr_r, regs_r[radr_r]};
      if (phy_req.valid && !phy_req_ack) begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == ack_delay) begin
            phy_req_ack <= 1'b1;
            cnt_r <= 4'h0;
            if (phy_req.write) regs_r[phy_req.addr] <= phy_req.data;
            else radr_r <= phy_req.addr;
            if (!phy_req.write) pend_r <= 3'd3;
         end
      end
      if (!aresetn) begin
         regs_r <= '{default: 8'h3f}; // Default gap count after reset
         cnt_r <= 4'h0;
         pend_r <= 3'd0;
         phy_reply <= '0;
      end
   end
endmodule // phy_model

// *** test/tb_link_regs.sv ***
// Testbench: register bank over AXI4-Lite with a behavioural phy
`timescale 1ns/100ps
module tb_link_regs import link_regs_pkg::*;;
   logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cycle_master, cycle_source;
   logic cycle_timer_enable, cycle_start_tick, arb_reset_gap_det, subaction_gap_det, phy_req_ack;
   logic phy_info_received_irq, memory_test_mode;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, d, v;
   logic [3:0] s_axi_wstrb, ack_delay;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   phy_req_s phy_req;
   phy_reply_s phy_reply;
   rx_ctrl_s rx_ctrl;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   int irqs = 0;

   link_regs i_link_regs (.*);
   phy_model i_phy_model (.aclk(aclk), .aresetn(aresetn), .ack_delay(ack_delay), .phy_req(phy_req),
      .phy_req_ack(phy_req_ack), .phy_reply(phy_reply));

   // ********************************
   // Helpers
   // ********************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] dat);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      axr(a);
      chk(d, exp);
      chk(32'(r), 32'(RESP_OKAY));
   endtask

   // Poll until the link has cleared a request bit; bounded so a stuck bit shows
   task automatic wait_req(input int b);
      int n;
      n = 0;
      do begin
         axr(OFF_PHY_ACCESS);
         n++;
      end while (d[b] && n < 20);
      chk(32'(d[b]), 32'h0);
   endtask

   // Clock and watchdog
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (phy_info_received_irq === 1'b1) irqs++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {cycle_master, cycle_source, cycle_timer_enable, cycle_start_tick} = '0;
      {arb_reset_gap_det, subaction_gap_det, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      clk_en = 1'b1;
      s_axi_wstrb = 4'hf;
      ack_delay = 4'h0;
      seed = 32'h3566056d;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(OFF_CYCLE_TIME, 32'h0);
      rchk(OFF_ISO_MATCH, 32'h0);
      rchk(OFF_DIAG, 32'h0);
      rchk(OFF_PHY_ACCESS, 32'h0);
      chk(32'({rx_ctrl.first_channel_enable, rx_ctrl.second_channel_enable}), 32'h3);
      // Random channel matches; reserved half must stay zero
      repeat (8) begin
         seed = xs(seed);
         axw(OFF_ISO_MATCH, seed);
         rchk(OFF_ISO_MATCH, {seed[31:16], 16'h0});
         chk(32'(rx_ctrl.first_channel_match), 32'(seed[31:24]));
         chk(32'(rx_ctrl.second_channel_match), 32'(seed[23:16]));
      end
      v = xs(seed);
      s_axi_wstrb <= 4'h8;
      axw(OFF_ISO_MATCH, v);
      s_axi_wstrb <= 4'hf;
      rchk(OFF_ISO_MATCH, {v[31:24], seed[23:16], 16'h0});
      // Locked diagnostic: only snoop and full access take a write
      axw(OFF_DIAG, 32'hc080_0000);
      rchk(OFF_DIAG, 32'h8000_0000);
      chk(32'({rx_ctrl.promiscuous_receive, rx_ctrl.busy_ack_select, memory_test_mode}), 32'h4);
      axw(OFF_DIAG, 32'h0800_0000);
      rchk(OFF_DIAG, 32'h0800_0000);
      axw(OFF_DIAG, 32'h4880_0000);
      rchk(OFF_DIAG, 32'h4880_0000);
      chk(32'({rx_ctrl.promiscuous_receive, rx_ctrl.busy_ack_select, memory_test_mode}), 32'h3);
      // Memory test: two words with tag set, read back with tag clear
      seed = xs(v);
      v = xs(seed);
      axw(OFF_DIAG, 32'h4e80_0000);
      axw(OFF_RAM_TEST, seed);
      axw(OFF_RAM_TEST, v);
      axw(OFF_DIAG, 32'h4c80_0000);
      rchk(OFF_RAM_TEST, seed);
      rchk(OFF_DIAG, 32'h4980_0000);
      rchk(OFF_RAM_TEST, v);
      axw(OFF_DIAG, 32'h4e80_0000);
      rchk(OFF_DIAG, 32'h4a80_0000);
      rchk(OFF_RAM_TEST, seed);
      rchk(OFF_DIAG, 32'h4a80_0000);
      axw(OFF_DIAG, 32'h0);
      rchk(OFF_DIAG, 32'h0);
      axr(OFF_RAM_TEST);
      chk(32'(r), 32'(RESP_SLVERR));
      axw(8'h1c, 32'hffff_ffff);
      chk(32'(r), 32'(RESP_SLVERR));
      @(posedge aclk);
      arb_reset_gap_det <= 1'b1;
      @(posedge aclk);
      arb_reset_gap_det <= 1'b0;
      rchk(OFF_DIAG, 32'h2000_0000);
      subaction_gap_det <= 1'b1;
      @(posedge aclk);
      subaction_gap_det <= 1'b0;
      rchk(OFF_DIAG, 32'h3000_0000);
      // Phy write then read back, prompt and slow acks
      for (int k = 0; k < 4; k++) begin
         ack_delay <= 4'(k * 3);
         seed = xs(seed);
         axw(OFF_PHY_ACCESS, {4'h7, seed[27:16], 16'hffff});
         wait_req(30);
         axw(OFF_PHY_ACCESS, {4'h8, seed[27:16], 16'h0});
         wait_req(31);
         repeat (8) @(posedge aclk);
         rchk(OFF_PHY_ACCESS, {4'h0, seed[27:16], 4'h0, seed[27:16]});
      end
      chk(32'(irqs), 32'd4);
      // Timer carry through offset, cycle and seconds
      axw(OFF_CYCLE_TIME, {7'd5, 13'd7999, 12'd3070});
      cycle_master <= 1'b1;
      cycle_timer_enable <= 1'b1;
      repeat (30) @(posedge aclk);
      axr(OFF_CYCLE_TIME);
      chk({12'h0, d[31:12]}, {12'h0, 7'd6, 13'd0});
      chk(32'(d[11:0] < 12'd8), 32'h1);
      // Cycle slave on external source: start pulse zeroes the offset and carries the cycle
      cycle_master <= 1'b0;
      cycle_source <= 1'b1;
      axw(OFF_CYCLE_TIME, {7'd2, 13'd7999, 12'd100});
      cycle_start_tick <= 1'b1;
      @(posedge aclk);
      cycle_start_tick <= 1'b0;
      axr(OFF_CYCLE_TIME);
      chk({12'h0, d[31:12]}, {12'h0, 7'd3, 13'd0});
      chk(32'(d[11:0] < 12'd8), 32'h1);
      end_sim();
   end
endmodule // tb_link_regs
